// file: hw/uwk_consts.svh
// Constants of the 8/9-bit serial channel with multiprocessor wake-up.
// Assumes ref_clk at 125 MHz; included by the channel module and the testbench.
`ifndef UWK_CONSTS_SVH
`define UWK_CONSTS_SVH
`define UWK_MODE_8BIT    2'h2
`define UWK_MODE_9BIT    2'h3
`define UWK_CLK_MHZ      125
`define UWK_BAUD_DIV     16'h0364
`define UWK_FIFO_DEPTH   32
`define UWK_FIFO_AW      5
`define UWK_DATA_W       9
`endif

// file: hw/uwk_pkg.sv
// Types shared by the serial channel modules.
// Takes nothing from uwk_consts.svh; only the channel module and the testbench include it.
`default_nettype none
package uwk_pkg;
	typedef struct packed {
		logic [1:0] serialModeSelect;
		logic       parityEnable;
		logic       parityOdd;
		logic       stopBitLength;
		logic       wakeupEnable;
		logic       rxEnable;
	} uwk_cfg_s;

	typedef enum logic [3:0] {
		UWK_IDLE  = 4'h1,
		UWK_START = 4'h2,
		UWK_BITS  = 4'h4,
		UWK_STOP  = 4'h8
	} uwk_state_e;
endpackage
`default_nettype wire

// file: hw/uwk_fifo.sv
// Flip-flop FIFO carrying received words to software.
// Assumes one clock, synchronous active-high reset and a clock enable.
`timescale 1ns/100ps
`default_nettype none
module uwk_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 32,
	parameter int AW    = 5
) (
	// Clock and reset
	input  wire logic             ref_clk,
	input  wire logic             rst,
	input  wire logic             clkEn,
	// Fill side
	input  wire logic             inValid,
	output logic                  inReady,
	input  wire logic [WIDTH-1:0] inData,
	// Drain side
	output logic                  outValid,
	input  wire logic             outReady,
	output logic      [WIDTH-1:0] outData
);
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0]    wrPtr_reg;
	logic [AW-1:0]    rdPtr_reg;
	logic [AW:0]      count_reg;
	wire              doWrite = inValid && inReady && clkEn;
	wire              doRead  = outValid && outReady && clkEn;

	// Honest flags straight from the occupancy count
	assign inReady  = (count_reg != (AW+1)'(DEPTH));
	assign outValid = (count_reg != '0);
	assign outData  = mem_reg[rdPtr_reg];

	// Storage writes need no reset
	always_ff @(posedge ref_clk)
	begin
		if (doWrite)
			mem_reg[wrPtr_reg] <= inData;
	end

	// Pointers and count
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			wrPtr_reg <= '0;
			rdPtr_reg <= '0;
			count_reg <= '0;
		end
		else
		begin
			if (doWrite)
				wrPtr_reg <= wrPtr_reg + 1'b1;
			if (doRead)
				rdPtr_reg <= rdPtr_reg + 1'b1;
			count_reg <= count_reg + (AW+1)'(doWrite) - (AW+1)'(doRead);
		end
	end

	AST_FIFO_NO_OVERFLOW: assert property (@(posedge ref_clk) disable iff (rst)
		count_reg <= (AW+1)'(DEPTH)) else $error("FIFO count above depth");
endmodule
`default_nettype wire

// file: hw/uwk_uart.sv
// Serial channel, 8-bit and 9-bit asynchronous modes with wake-up.
// Assumes rxPin is already synchronised to ref_clk; bit time is baudDiv cycles.
`timescale 1ns/100ps
`default_nettype none
`include "uwk_consts.svh"
module uwk_uart
	import uwk_pkg::*;
(
	// Clock, reset, enable
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic        clkEn,
	// Configuration
	input  wire uwk_cfg_s    cfg,
	input  wire logic [15:0] baudDiv,
	// Transmit request
	input  wire logic        txValid,
	output logic             txReady,
	input  wire logic [7:0]  txData,
	input  wire logic        txNinthBit,
	// Received words
	output logic             rxValid,
	input  wire logic        rxReady,
	output logic [7:0]       rxData,
	output logic             rxNinthBit,
	output logic             rxInterrupt,
	output logic             parityError,
	output logic             overrunError,
	// Line pins; open drain when openDrainControl is set
	input  wire logic        openDrainControl,
	input  wire logic        rxPin,
	output logic             txOut,
	output logic             txOe
);
	// Derived mode decode
	wire mode8  = (cfg.serialModeSelect == `UWK_MODE_8BIT);
	wire mode9  = (cfg.serialModeSelect == `UWK_MODE_9BIT);
	wire useExtra8 = mode8 && cfg.parityEnable;
	wire active = mode8 || mode9;
	wire [15:0] halfDiv = {1'b0, baudDiv[15:1]};

	// Transmitter
	uwk_state_e  txState_reg;
	logic [15:0] txCnt_reg;
	logic [3:0]  txBit_reg;
	logic [8:0]  txShift_reg;
	logic [3:0]  txBits_reg;
	logic        txStop2_reg;
	logic        txLine_reg;
	wire         txTick = (txCnt_reg == 16'h0000);
	wire         txParity = ^txData ^ cfg.parityOdd;
	wire [8:0]   txWord = mode9 ? {txNinthBit, txData} : {txParity, txData};
	wire [3:0]   txNbits = (mode9 || useExtra8) ? 4'h9 : 4'h8;
	// Wake-up state never blocks sending, so a selected slave can answer
	assign txReady = (txState_reg == UWK_IDLE) && active && clkEn;

	// Open drain drives only the low level; push-pull drives always
	assign txOut = txLine_reg;
	assign txOe  = openDrainControl ? !txLine_reg : 1'b1;

	// Transmit frame sequencer
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			txState_reg <= UWK_IDLE;
			txCnt_reg   <= 16'h0000;
			txBit_reg   <= 4'h0;
			txShift_reg <= 9'h1FF;
			txBits_reg  <= 4'h8;
			txStop2_reg <= 1'b0;
			txLine_reg  <= 1'b1;
		end
		else if (clkEn)
		begin
			txCnt_reg <= txTick ? baudDiv - 16'h0001 : txCnt_reg - 16'h0001;
			case (txState_reg)
				UWK_IDLE:
				begin
					txLine_reg <= 1'b1;
					if (txValid && txReady)
					begin
						txShift_reg <= txWord;
						txBits_reg  <= txNbits;
						txStop2_reg <= mode9 && cfg.stopBitLength;
						txCnt_reg   <= baudDiv - 16'h0001;
						txLine_reg  <= 1'b0;
						txState_reg <= UWK_START;
					end
				end
				UWK_START:
					if (txTick)
					begin
						txLine_reg  <= txShift_reg[0];
						txShift_reg <= {1'b1, txShift_reg[8:1]};
						txBit_reg   <= 4'h1;
						txState_reg <= UWK_BITS;
					end
				UWK_BITS:
					if (txTick)
					begin
						if (txBit_reg == txBits_reg)
						begin
							txLine_reg  <= 1'b1;
							txBit_reg   <= 4'h0;
							txState_reg <= UWK_STOP;
						end
						else
						begin
							txLine_reg  <= txShift_reg[0];
							txShift_reg <= {1'b1, txShift_reg[8:1]};
							txBit_reg   <= txBit_reg + 4'h1;
						end
					end
				UWK_STOP:
					if (txTick)
					begin
						if (txStop2_reg && txBit_reg == 4'h0)
							txBit_reg <= 4'h1;
						else
							txState_reg <= UWK_IDLE;
					end
				default: txState_reg <= UWK_IDLE;
			endcase
		end
	end

	// Receiver
	uwk_state_e  rxState_reg;
	logic [15:0] rxCnt_reg;
	logic [3:0]  rxBit_reg;
	logic [8:0]  rxShift_reg;
	logic [3:0]  rxBits_reg;
	logic        rxDone_reg;
	wire         rxTick = (rxCnt_reg == 16'h0000);
	wire [8:0]   rxAligned = (rxBits_reg == 4'h9) ? rxShift_reg : {1'b0, rxShift_reg[8:1]};
	wire         rxParBad = useExtra8 && ((^rxAligned) != cfg.parityOdd);
	// Wake-up filter: drop address-less frames while waiting for selection
	wire         rxKeep = !(mode9 && cfg.wakeupEnable) || rxAligned[8];
	wire         fifoInReady;
	wire         pushWord = rxDone_reg && rxKeep;

	// Receive frame sequencer; samples mid-bit
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			rxState_reg  <= UWK_IDLE;
			rxCnt_reg    <= 16'h0000;
			rxBit_reg    <= 4'h0;
			rxShift_reg  <= 9'h000;
			rxBits_reg   <= 4'h8;
			rxDone_reg   <= 1'b0;
		end
		else if (clkEn)
		begin
			rxDone_reg <= 1'b0;
			rxCnt_reg  <= rxTick ? baudDiv - 16'h0001 : rxCnt_reg - 16'h0001;
			case (rxState_reg)
				UWK_IDLE:
					if (cfg.rxEnable && active && !rxPin)
					begin
						rxCnt_reg   <= halfDiv;
						rxBits_reg  <= txNbits;
						rxState_reg <= UWK_START;
					end
				UWK_START:
					if (rxTick)
					begin
						rxBit_reg   <= 4'h0;
						rxState_reg <= rxPin ? UWK_IDLE : UWK_BITS; // False start glitch
					end
				UWK_BITS:
					if (rxTick)
					begin
						rxShift_reg <= {rxPin, rxShift_reg[8:1]};
						rxBit_reg   <= rxBit_reg + 4'h1;
						if (rxBit_reg + 4'h1 == rxBits_reg)
							rxState_reg <= UWK_STOP;
					end
				UWK_STOP:
					if (rxTick)
					begin
						rxDone_reg   <= 1'b1;
						rxState_reg  <= UWK_IDLE;
					end
				default: rxState_reg <= UWK_IDLE;
			endcase
		end
	end

	// Received word store and sticky errors
	logic [8:0] fifoOut;
	logic       rxInt_reg;
	logic       parErr_reg;
	logic       ovr_reg;
	uwk_fifo #(
		.WIDTH(`UWK_DATA_W),
		.DEPTH(`UWK_FIFO_DEPTH),
		.AW   (`UWK_FIFO_AW)
	) u_fifo (
		.ref_clk (ref_clk),
		.rst     (rst),
		.clkEn   (clkEn),
		.inValid (pushWord),
		.inReady (fifoInReady),
		.inData  (rxAligned),
		.outValid(rxValid),
		.outReady(rxReady),
		.outData (fifoOut)
	);
	assign rxData     = fifoOut[7:0];
	assign rxNinthBit = mode9 ? fifoOut[8] : 1'b0;
	assign rxInterrupt  = rxInt_reg;
	assign parityError  = parErr_reg;
	assign overrunError = ovr_reg;

	// Interrupt pulse for each kept frame; errors sticky until rx disabled
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			rxInt_reg  <= 1'b0;
			parErr_reg <= 1'b0;
			ovr_reg    <= 1'b0;
		end
		else if (clkEn)
		begin
			rxInt_reg  <= pushWord;
			parErr_reg <= (pushWord && rxParBad) || (parErr_reg && cfg.rxEnable);
			ovr_reg    <= (pushWord && !fifoInReady) || (ovr_reg && cfg.rxEnable);
		end
	end

	AST_WAKE_DROP: assert property (@(posedge ref_clk) disable iff (rst)
		clkEn && rxDone_reg && mode9 && cfg.wakeupEnable && !rxAligned[8] |=> !rxInterrupt)
		else $error("Interrupt on dropped wake-up frame");
	AST_RX_INT: assert property (@(posedge ref_clk) disable iff (rst)
		clkEn && rxDone_reg && (!cfg.wakeupEnable || rxAligned[8]) |=> rxInterrupt)
		else $error("Kept frame raised no interrupt");
	AST_START_LOW: assert property (@(posedge ref_clk) disable iff (rst)
		txState_reg == UWK_START |-> !txOut) else $error("Start bit not low");
	AST_IDLE_HIGH: assert property (@(posedge ref_clk) disable iff (rst)
		txState_reg == UWK_IDLE && $past(txState_reg) == UWK_STOP |-> txOut)
		else $error("Line not high after stop");
	AST_OD: assert property (@(posedge ref_clk) disable iff (rst)
		openDrainControl && txOut |-> !txOe) else $error("Open drain drove high");
	AST_NINTH: assert property (@(posedge ref_clk) disable iff (rst)
		clkEn && txValid && txReady && mode9 |=> txShift_reg[8] == $past(txNinthBit))
		else $error("Ninth bit not loaded");
	AST_STOP2: assert property (@(posedge ref_clk) disable iff (rst)
		clkEn && txValid && txReady |=> txStop2_reg == $past(mode9 && cfg.stopBitLength))
		else $error("Stop length wrong");
	AST_LEN: assert property (@(posedge ref_clk) disable iff (rst)
		clkEn && txValid && txReady && mode8 |=> txBits_reg == ($past(cfg.parityEnable) ? 4'h9 : 4'h8))
		else $error("Frame length wrong");
endmodule
`default_nettype wire

// file: sim/uwk_line_partner.sv
// Far-side controller on the shared line: sends frames, decodes frames.
// Assumes bit time of b ref_clk cycles; line rests high by pull-up.
`timescale 1ns/100ps
`default_nettype none
module uwk_line_partner (
	// Clock
	input  wire logic ref_clk,
	// Line
	input  wire logic lineIn,
	output logic      lineOut
);
	initial lineOut = 1'b1;
	// Start low, n bits LSB first, one high stop
	task automatic send(input logic [9:0] w, input int n, input int b);
		for (int k = 0; k < n + 2; k++)
		begin
			lineOut = (k == 0) ? 1'b0 : (k == n + 1) ? 1'b1 : w[k-1];
			repeat (b) @(negedge ref_clk);
		end
	endtask
	// Mid-bit sampling; bits never seen stay high
	task automatic recv(input int n, input int b, output logic [9:0] w);
		int t;
		t = 0;
		w = '1;
		while (lineIn !== 1'b0 && t < 100)
		begin
			@(negedge ref_clk);
			t++;
		end
		repeat (b / 2) @(negedge ref_clk);
		for (int k = 0; k < n; k++)
		begin
			repeat (b) @(negedge ref_clk);
			w[k] = lineIn;
		end
	endtask
endmodule
`default_nettype wire

// file: sim/uwk_uart_tb.sv
// Self-checking bench: transmit framing, parity, wake-up, FIFO overrun.
// Assumes the far-side model in uwk_line_partner.sv and a short bit time.
`timescale 1ns/100ps
`default_nettype none
`include "uwk_consts.svh"
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin numErrors++; $display("unexpected at %0t: got %h want %h", $time, a, e); end end
module uwk_uart_tb;
	import uwk_pkg::*;
	localparam int B = 8; // Short bit time keeps the run brief
	logic refClk = 1'b0, rst = 1'b1, clkEn = 1'b1, txValid = 1'b0, txNinthBit = 1'b0;
	logic rxReady = 1'b0, openDrainControl = 1'b0, rxPin;
	logic [7:0] txData = 8'h00, rxData;
	logic [15:0] baudDiv = 16'h0008;
	logic rxValid, txReady, rxNinthBit, rxInterrupt, parityError, overrunError, txOut, txOe;
	uwk_cfg_s cfg = '0;
	int numErrors = 0, compares = 0, cycles = 0, irqs = 0;
	logic [31:0] seed = 32'h00015D85;
	// Shared line: released pin floats to the pull-up
	wire logic lineLevel = txOe ? txOut : 1'b1;
	uwk_uart DUT (.ref_clk(refClk), .rst(rst), .clkEn(clkEn), .cfg(cfg), .baudDiv(baudDiv), .txValid(txValid),
		.txReady(txReady), .txData(txData), .txNinthBit(txNinthBit), .rxValid(rxValid), .rxReady(rxReady),
		.rxData(rxData), .rxNinthBit(rxNinthBit), .rxInterrupt(rxInterrupt), .parityError(parityError),
		.overrunError(overrunError), .openDrainControl(openDrainControl), .rxPin(rxPin), .txOut(txOut),
		.txOe(txOe));
	uwk_line_partner farEnd (.ref_clk(refClk), .lineIn(lineLevel), .lineOut(rxPin));
	always #4 refClk = ~refClk;
	// Interrupt tally and hang limit
	always @(posedge refClk)
	begin
		irqs += (rxInterrupt === 1'b1);
		cycles++;
		if (cycles == 20000)
		begin
			numErrors++;
			printVerdict();
		end
	end
	function automatic logic [31:0] nextRand();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// Bits after the start bit, stop included
	function automatic logic [9:0] frameWord(input logic [7:0] d, input logic nb);
		if (cfg.serialModeSelect == `UWK_MODE_9BIT)
			return {1'b1, nb, d};
		if (cfg.parityEnable)
			return {1'b1, cfg.parityOdd ^ (^d), d};
		return {2'h3, d};
	endfunction
	function automatic int nBits();
		return (cfg.serialModeSelect == `UWK_MODE_9BIT || cfg.parityEnable) ? 9 : 8;
	endfunction
	task automatic pop();
		rxReady = 1'b1;
		@(negedge refClk);
		rxReady = 1'b0;
		@(negedge refClk);
	endtask
	task automatic txCheck(input logic [7:0] d, input logic nb);
		logic [9:0] w;
		fork
			begin
				txNinthBit = nb;
				txData = d;
				txValid = 1'b1;
				for (int t = 0; t < 50 && txReady !== 1'b1; t++)
					@(negedge refClk);
				@(negedge refClk);
				txValid = 1'b0;
			end
			farEnd.recv(nBits() + 1, B, w);
		join
		`CHK(w, frameWord(d, nb))
		repeat (B) @(negedge refClk);
		`CHK(lineLevel, 1'b1)
		`CHK(txReady, !(cfg.serialModeSelect == `UWK_MODE_9BIT && cfg.stopBitLength))
	endtask
	task automatic rxCheck(input logic [7:0] d, input logic nb, input logic keep, input logic bad);
		int i0;
		i0 = irqs;
		farEnd.send(frameWord(d, nb) ^ {1'b0, bad, 8'h00}, nBits(), B);
		repeat (B) @(negedge refClk);
		`CHK(irqs - i0, int'(keep))
		`CHK(rxValid, keep)
		if (keep)
		begin
			`CHK(rxData, d)
			`CHK(rxNinthBit, nb & (cfg.serialModeSelect == `UWK_MODE_9BIT))
			`CHK(parityError, bad)
			pop();
		end
	endtask
	task automatic printVerdict();
		$display("compares %0d, errors %0d", compares, numErrors);
		if (numErrors == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Main sequence
	initial
	begin
		logic [7:0] q[$];
		logic [7:0] d;
		cfg.rxEnable = 1'b1;
		repeat (6) @(negedge refClk);
		rst = 1'b0;
		`CHK(txReady, 1'b0)
		// Plain, even, odd, then 9-bit with one and two stops
		for (int m = 0; m < 5; m++)
		begin
			cfg.serialModeSelect = (m < 3) ? `UWK_MODE_8BIT : `UWK_MODE_9BIT;
			cfg.parityEnable = (m == 1 || m == 2);
			cfg.parityOdd = (m == 2);
			cfg.stopBitLength = (m == 4);
			@(negedge refClk);
			for (int k = 0; k < 3; k++)
			begin
				d = 8'(nextRand());
				txCheck(k == 0 ? 8'hFF : d, 1'(nextRand()));
				rxCheck(d, k[0], 1'b1, 1'b0);
			end
			if (cfg.parityEnable)
			begin
				rxCheck(8'h96, 1'b0, 1'b1, 1'b1);
				cfg.rxEnable = 1'b0;
				@(negedge refClk);
				cfg.rxEnable = 1'b1;
				@(negedge refClk);
			end
		end
		// Slave wake-up: dropped data, select code, then addressed data
		cfg.stopBitLength = 1'b0;
		cfg.wakeupEnable = 1'b1;
		rxCheck(8'h5A, 1'b0, 1'b0, 1'b0);
		rxCheck(8'h3C, 1'b1, 1'b1, 1'b0);
		cfg.wakeupEnable = 1'b0;
		rxCheck(8'hC3, 1'b0, 1'b1, 1'b0);
		// Selected slave answers over an open-drain pin
		openDrainControl = 1'b1;
		@(negedge refClk);
		`CHK(txOe, 1'b0)
		txCheck(8'hA5, 1'b1);
		openDrainControl = 1'b0;
		clkEn = 1'b0;
		@(negedge refClk);
		`CHK(txReady, 1'b0)
		clkEn = 1'b1;
		// Back-to-back frames with nobody draining: 32 kept, one lost
		cfg.serialModeSelect = `UWK_MODE_8BIT;
		for (int k = 0; k < 33; k++)
		begin
			d = 8'(nextRand());
			q.push_back(d);
			farEnd.send({2'h3, d}, 8, B);
		end
		repeat (B) @(negedge refClk);
		`CHK(overrunError, 1'b1)
		for (int k = 0; k < 32; k++)
		begin
			`CHK(rxData, q[k])
			pop();
		end
		`CHK(rxValid, 1'b0)
		printVerdict();
	end
endmodule
`default_nettype wire
